// File: rtl/pmic_pkg.sv
// Package: register map, reset values and carrier types of the PMIC bank
package pmic_pkg;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] ADDR_PWR_CTL = 8'h01;
  localparam logic [7:0] ADDR_STATUS  = 8'h0D;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0E;
  localparam logic [7:0] ADDR_MASK    = 8'h0F;
  localparam logic [7:0] ADDR_SHUT    = 8'h10;
  localparam logic [7:0] ADDR_DEFAULT = 8'h11;
  localparam logic [7:0] ADDR_PROT    = 8'h12;
  localparam logic [7:0] ADDR_DISCH   = 8'h13;
  localparam logic [7:0] ADDR_PGMON   = 8'h14;

  // ==========================================================
  // Command keys
  // ==========================================================
  localparam logic [7:0] KEY_SHUT    = 8'hA9;
  localparam logic [7:0] KEY_DEFAULT = 8'h7F;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_PWR_CTL = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [7:0] RST_PROT  = 8'h01;
  localparam logic [7:0] RST_DISCH = 8'h0F;
  localparam logic [7:0] RST_PGMON = 8'h01;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int PROT_HICCUP   = 0;
  localparam int PROT_SC_LATCH = 1;
  localparam int PROT_OV_LATCH = 2;
  localparam int PROT_BTN_SW   = 3;
  localparam int EVT_BTN       = 6;
  localparam int EVT_TEMP      = 5;
  localparam int EVT_LVIN      = 4;

  // Bus address of the device, 7 bits
  localparam logic [6:0] DEV_ADDR = 7'h4A;

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } pmic_wr_t;

  typedef struct packed {
    logic       btn_n;
    logic [3:0] en;
    logic       hot;
    logic       lvin;
    logic [3:0] pg;
  } pmic_pins_t;

endpackage

// File: rtl/pmic_link.sv
// Two-wire serial slave running on the bus clock
`timescale 1ns/1ns
module pmic_link (
  // Link pins
  input  wire logic             scl_clk,
  input  wire logic             rstn,
  input  wire logic             sda_i,
  output logic                  sda_oe,
  // Toward the register bank
  output logic                  wr_tog,
  output pmic_pkg::pmic_wr_t    wr_pkt,
  output logic [7:0]            ptr,
  input  wire logic [7:0]       rd_data
);

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_ADDR  = 3'b001,
    L_PTR   = 3'b010,
    L_WDATA = 3'b011,
    L_RDATA = 3'b100
  } pmic_lst_t;

  pmic_lst_t  state_r;
  logic       st_tog_r;
  logic       st_seen_r;
  logic [3:0] bitcnt_r;
  logic [6:0] sh_r;
  logic       ack_r;
  logic [7:0] tx_r;

  wire       new_frame = st_tog_r != st_seen_r;
  wire [7:0] byte_in   = {sh_r, sda_i};
  wire       byte_done = bitcnt_r == 4'h7;
  wire       tx_bit    = (bitcnt_r == 4'h0) ? rd_data[7]
                         : tx_r[3'(4'h7 - bitcnt_r)];

  // ==========================================================
  // Start condition: data falls while clock is high
  // ==========================================================
  always_ff @(negedge sda_i or negedge rstn) begin
    if (!rstn) begin
      st_tog_r <= 1'b0;
    end else if (scl_clk) begin
      st_tog_r <= ~st_tog_r;
    end
  end

  // ==========================================================
  // Bit sampling on rising clock
  // ==========================================================
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= L_IDLE;
      st_seen_r <= 1'b0;
      bitcnt_r  <= 4'h0;
      sh_r      <= 7'h00;
      ack_r     <= 1'b0;
      wr_tog    <= 1'b0;
      wr_pkt    <= '0;
      ptr       <= 8'h00;
    end else if (new_frame) begin
      st_seen_r <= st_tog_r;
      state_r   <= L_ADDR;
      bitcnt_r  <= 4'h1;
      sh_r      <= {6'h00, sda_i};
      ack_r     <= 1'b0;
    end else if (state_r != L_IDLE) begin
      sh_r     <= byte_in[6:0];
      bitcnt_r <= (bitcnt_r == 4'h8) ? 4'h0 : bitcnt_r + 4'h1;
      if (bitcnt_r == 4'h8) begin
        ack_r <= 1'b0;
        if (state_r == L_RDATA && sda_i) begin
          state_r <= L_IDLE;
        end
      end else if (byte_done) begin
        unique case (state_r)
          L_ADDR: begin
            ack_r   <= byte_in[7:1] == pmic_pkg::DEV_ADDR;
            state_r <= (byte_in[7:1] != pmic_pkg::DEV_ADDR) ? L_IDLE
                       : (byte_in[0] ? L_RDATA : L_PTR);
          end
          L_PTR: begin
            ack_r   <= 1'b1;
            ptr     <= byte_in;
            state_r <= L_WDATA;
          end
          L_WDATA: begin
            ack_r  <= 1'b1;
            wr_pkt <= '{addr: ptr, data: byte_in};
            wr_tog <= ~wr_tog;
            ptr    <= ptr + 8'h01;
          end
          L_RDATA: ack_r <= 1'b0;
          default: state_r <= L_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Drive on falling clock: acknowledge and read data
  // ==========================================================
  always_ff @(negedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe <= 1'b0;
      tx_r   <= 8'h00;
    end else begin
      if (state_r == L_RDATA && bitcnt_r == 4'h0) begin
        tx_r <= rd_data;
      end
      if (ack_r && bitcnt_r == 4'h8) begin
        sda_oe <= 1'b1;
      end else if (state_r == L_RDATA && bitcnt_r < 4'h8) begin
        sda_oe <= ~tx_bit;
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

endmodule // pmic_link

// File: rtl/pmic_regs.sv
// Interrupt mask, keyed commands and default settings of the PMIC bank
`timescale 1ns/1ns
module pmic_regs (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Serial link
  input  wire logic       scl_clk,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Pins from the board and the analog side
  input  wire logic       manual_reset_button_n,
  input  wire logic [3:0] channel_enable_pins,
  input  wire logic       overheat_warn,
  input  wire logic       low_input_warn,
  input  wire logic [3:0] ch_power_good,
  // Interrupt pin, open drain
  output logic            interrupt_n_o,
  output logic            interrupt_n_oe,
  // Controls toward the regulators
  output logic [3:0]      ch_regulator_on,
  output logic [3:0]      discharge_en,
  output logic            hiccup_en,
  output logic            short_latch_en,
  output logic            ov_latch_en,
  output logic            btn_switch_mode,
  output logic            power_good_output
);

  // ==========================================================
  // Link and its crossing
  // ==========================================================
  logic               wr_tog;
  pmic_pkg::pmic_wr_t wr_pkt;
  logic [7:0]         link_ptr;
  logic [7:0]         rd_word_r;
  logic               link_oe;

  pmic_link u_link (
    .scl_clk (scl_clk),
    .rstn    (rstn),
    .sda_i   (sda_i),
    .sda_oe  (link_oe),
    .wr_tog  (wr_tog),
    .wr_pkt  (wr_pkt),
    .ptr     (link_ptr),
    .rd_data (rd_word_r)
  );

  logic [2:0] tog_sync_r;
  logic [7:0] ptr_s1_r;
  logic [7:0] ptr_s2_r;
  logic [7:0] ptr_s3_r;
  logic [7:0] ptr_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic       wr_evt_r;

  // Write event: toggle passes two flops, then its change is taken
  wire wr_evt_nxt = tog_sync_r[2] != tog_sync_r[1];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tog_sync_r <= 3'h0;
      ptr_s1_r   <= 8'h00;
      ptr_s2_r   <= 8'h00;
      ptr_s3_r   <= 8'h00;
      ptr_r      <= 8'h00;
      wr_evt_r   <= 1'b0;
      wr_addr_r  <= 8'h00;
      wr_data_r  <= 8'h00;
    end else begin
      tog_sync_r <= {tog_sync_r[1:0], wr_tog};
      ptr_s1_r   <= link_ptr;
      ptr_s2_r   <= ptr_s1_r;
      ptr_s3_r   <= ptr_s2_r;
      wr_evt_r   <= wr_evt_nxt;
      // Pointer taken only once two synced samples agree
      if (ptr_s3_r == ptr_s2_r) begin
        ptr_r <= ptr_s3_r;
      end
      if (wr_evt_nxt) begin
        wr_addr_r <= wr_pkt.addr;
        wr_data_r <= wr_pkt.data;
      end
    end
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  pmic_pkg::pmic_pins_t pins_raw;
  pmic_pkg::pmic_pins_t pins_s1_r;
  pmic_pkg::pmic_pins_t pins_now_r;
  pmic_pkg::pmic_pins_t pins_old_r;

  assign pins_raw = '{btn_n: manual_reset_button_n,
                      en:   channel_enable_pins,
                      hot:  overheat_warn,
                      lvin: low_input_warn,
                      pg:   ch_power_good};

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          pins_s1_r[gi]  <= 1'b0;
          pins_now_r[gi] <= 1'b0;
          pins_old_r[gi] <= 1'b0;
        end else begin
          pins_s1_r[gi]  <= pins_raw[gi];
          pins_now_r[gi] <= pins_s1_r[gi];
          pins_old_r[gi] <= pins_now_r[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [7:0] power_control_reg_r;
  logic [7:0] mask_r;
  logic [7:0] prot_r;
  logic [7:0] disch_r;
  logic [7:0] pgmon_r;
  logic [6:0] flags_r;

  wire sw_mode   = prot_r[pmic_pkg::PROT_BTN_SW];
  wire wr_pwrctl = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_PWR_CTL;
  wire wr_mask   = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_MASK;
  wire wr_prot   = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_PROT;
  wire wr_disch  = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_DISCH;
  wire wr_pgmon  = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_PGMON;
  wire wr_flags  = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_FLAGS;
  // Keyed commands; any other value falls through unused
  wire cmd_shut  = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_SHUT
                   && wr_data_r == pmic_pkg::KEY_SHUT
                   && sw_mode;
  wire cmd_dflt  = wr_evt_r && wr_addr_r == pmic_pkg::ADDR_DEFAULT
                   && wr_data_r == pmic_pkg::KEY_DEFAULT;

  always_ff @(posedge clk) begin
    if (!rstn || cmd_dflt) begin
      power_control_reg_r <= pmic_pkg::RST_PWR_CTL;
      mask_r  <= pmic_pkg::RST_MASK;
      prot_r  <= pmic_pkg::RST_PROT;
      disch_r <= pmic_pkg::RST_DISCH;
      pgmon_r <= pmic_pkg::RST_PGMON;
    end else begin
      if (cmd_shut) begin
        power_control_reg_r <= pmic_pkg::RST_PWR_CTL;
      end else if (wr_pwrctl) begin
        power_control_reg_r <= wr_data_r;
      end
      if (wr_mask) begin
        mask_r <= wr_data_r;
      end
      if (wr_prot) begin
        prot_r <= wr_data_r;
      end
      if (wr_disch) begin
        disch_r <= wr_data_r;
      end
      if (wr_pgmon) begin
        pgmon_r <= wr_data_r;
      end
    end
  end

  // ==========================================================
  // Event flags
  // ==========================================================
  wire       btn_press = sw_mode && pins_old_r.btn_n && !pins_now_r.btn_n;
  wire       hot_rise  = pins_now_r.hot && !pins_old_r.hot;
  wire       lvin_rise = pins_now_r.lvin && !pins_old_r.lvin;
  wire [3:0] pg_fail   = pins_old_r.pg & ~pins_now_r.pg
                         & power_control_reg_r[3:0];
  wire [6:0] flag_set  = {btn_press, hot_rise, lvin_rise, pg_fail};
  wire       all_off   = pins_now_r.en == 4'h0;
  // Write one to clear; all enables low or defaults clear all
  wire [6:0] flag_clr  = (wr_flags ? wr_data_r[6:0] : 7'h00)
                         | {7{all_off || cmd_dflt}};
  // Set wins over a clear in the same cycle
  wire [6:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_r <= 7'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // Interrupt pin
  // ==========================================================
  // Button enable is void outside switch mode
  wire [6:0] mask_eff = {mask_r[pmic_pkg::EVT_BTN] & sw_mode,
                         mask_r[5:0]};
  wire       irq_any  = |(flags_r & mask_eff);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      interrupt_n_o  <= 1'b0;
      interrupt_n_oe <= 1'b0;
    end else begin
      interrupt_n_o  <= 1'b0;
      interrupt_n_oe <= irq_any;
    end
  end

  // ==========================================================
  // Read data for the link
  // ==========================================================
  wire [7:0] status_rd = {1'b0, sw_mode & ~pins_now_r.btn_n, 2'b00,
                          pins_now_r.pg};
  wire [7:0] rd_mux =
      (ptr_r == pmic_pkg::ADDR_PWR_CTL) ? power_control_reg_r :
      (ptr_r == pmic_pkg::ADDR_STATUS) ? status_rd :
      (ptr_r == pmic_pkg::ADDR_FLAGS)  ? {1'b0, flags_r} :
      (ptr_r == pmic_pkg::ADDR_MASK)   ? mask_r :
      (ptr_r == pmic_pkg::ADDR_PROT)   ? prot_r :
      (ptr_r == pmic_pkg::ADDR_DISCH)  ? disch_r :
      (ptr_r == pmic_pkg::ADDR_PGMON)  ? pgmon_r : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_word_r <= 8'h00;
    end else begin
      rd_word_r <= rd_mux;
    end
  end

  // ==========================================================
  // Regulator controls and power-good pin
  // ==========================================================
  wire       pg_ok  = &(pins_now_r.pg | ~pgmon_r[3:0]);
  wire [3:0] ch_on  = power_control_reg_r[3:0] & pins_now_r.en;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ch_regulator_on   <= 4'h0;
      discharge_en      <= 4'hF;
      hiccup_en         <= 1'b1;
      short_latch_en    <= 1'b0;
      ov_latch_en       <= 1'b0;
      btn_switch_mode   <= 1'b0;
      power_good_output <= 1'b0;
      sda_o             <= 1'b0;
    end else begin
      ch_regulator_on   <= ch_on;
      discharge_en      <= disch_r[3:0];
      hiccup_en         <= prot_r[pmic_pkg::PROT_HICCUP];
      short_latch_en    <= prot_r[pmic_pkg::PROT_SC_LATCH];
      ov_latch_en       <= prot_r[pmic_pkg::PROT_OV_LATCH];
      btn_switch_mode   <= sw_mode;
      power_good_output <= pg_ok;
      sda_o             <= 1'b0;
    end
  end

  // Data pin enable comes straight from the link's falling-edge flop
  assign sda_oe = link_oe;

endmodule // pmic_regs

// File: tb/pmic_regs_chk.sv
// Checker: reset defaults and interrupt pin behaviour of the PMIC bank
`timescale 1ns/1ns
module pmic_regs_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Observed pins
  input wire logic [3:0] channel_enable_pins,
  input wire logic       interrupt_n_o,
  input wire logic       interrupt_n_oe,
  input wire logic [3:0] ch_regulator_on,
  input wire logic [3:0] discharge_en,
  input wire logic       hiccup_en,
  input wire logic       short_latch_en,
  input wire logic       ov_latch_en,
  input wire logic       btn_switch_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================
  // Sequences
  sequence s_rel;
    $rose(rstn);
  endsequence
  sequence s_en_low;
    (channel_enable_pins == 4'h0) [*8];
  endsequence

  // ==========================================
  // Properties
  AST_DEF_DISCH: assert property (s_rel |-> discharge_en == 4'hF)
    else $error("discharge enable wrong after reset");
  AST_DEF_HICCUP: assert property (s_rel |-> hiccup_en)
    else $error("hiccup protection off after reset");
  AST_DEF_SC: assert property (s_rel |-> !short_latch_en)
    else $error("short latch-off on after reset");
  AST_DEF_OV: assert property (s_rel |-> !ov_latch_en)
    else $error("overvoltage latch-off on after reset");
  AST_DEF_MODE: assert property (s_rel |-> !btn_switch_mode)
    else $error("button mode not processor reset after reset");
  AST_DEF_REGON: assert property (s_rel |-> ch_regulator_on == 4'h0)
    else $error("regulators on after reset");
  AST_IRQ_QUIET: assert property (s_rel |-> !interrupt_n_oe [*3])
    else $error("interrupt active with default mask");
  AST_INT_OD: assert property (interrupt_n_o == 1'b0)
    else $error("interrupt pin driven high");
  AST_EN_CLR: assert property (s_en_low |-> !interrupt_n_oe)
    else $error("interrupt held with all enables low");
endmodule // pmic_regs_chk

bind pmic_regs pmic_regs_chk pmic_regs_chk_i (
  .clk                 (clk),
  .rstn                (rstn),
  .channel_enable_pins (channel_enable_pins),
  .interrupt_n_o       (interrupt_n_o),
  .interrupt_n_oe      (interrupt_n_oe),
  .ch_regulator_on     (ch_regulator_on),
  .discharge_en        (discharge_en),
  .hiccup_en           (hiccup_en),
  .short_latch_en      (short_latch_en),
  .ov_latch_en         (ov_latch_en),
  .btn_switch_mode     (btn_switch_mode)
);

// File: tb/pmic_host.sv
// Two-wire bus host model for the PMIC bank link pins
`timescale 1ns/1ns
module pmic_host (
  // Link pins
  output logic      scl_clk,
  output logic      sda_i,
  input  wire logic sda_oe
);
  localparam logic [7:0] WR = {pmic_pkg::DEV_ADDR, 1'b0};
  logic pull;

  // Open-drain data wire with pull-up; clock idles high between frames
  assign sda_i = !(pull || sda_oe);
  initial begin
    scl_clk = 1'b1;
    pull = 1'b0;
  end

  // ==========================================
  // Bus cycles
  task automatic start;
    pull = 1'b1;
    #62 scl_clk = 1'b0;
  endtask
  task automatic stop;
    #31 pull = 1'b1;
    #31 scl_clk = 1'b1;
    #31 pull = 1'b0;
    #62;
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #31 pull = !d[i];
      #31 scl_clk = 1'b1;
      q[i] = sda_i;
      #63 scl_clk = 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [8:0] q;
    start;
    xfer({WR, 1'b1}, q);
    xfer({a, 1'b1}, q);
    xfer({d, 1'b1}, q);
    stop;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] q;
    start;
    xfer({WR, 1'b1}, q);
    xfer({a, 1'b1}, q);
    stop;
    start;
    xfer({WR | 8'h01, 1'b1}, q);
    xfer(9'h1FF, q);
    v = q[8:1];
    stop;
  endtask
endmodule // pmic_host

// File: tb/pmic_irq_mask_and_commands_bench.sv
// Self-checking bench for the PMIC interrupt mask and command registers
`timescale 1ns/1ns
module pmic_irq_mask_and_commands_bench;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] ex;
  } pmic_row_t;

  // ==========================================
  // Signals
  logic                 clk;
  logic                 rstn;
  logic                 scl_clk;
  logic                 sda_i;
  logic                 sda_oe;
  pmic_pkg::pmic_pins_t pins;
  logic                 irq_oe;
  logic [3:0]           reg_on;
  logic [3:0]           disch;
  logic                 hic;
  logic                 sc_l;
  logic                 ov_l;
  logic                 sw_mode;
  logic                 pgood;
  logic [7:0]           q;
  logic                 b;
  int                   mismatches;
  int                   total_checks;
  pmic_row_t            rows [11];

  initial clk = 1'b0;
  always #20 clk = !clk;

  pmic_regs pmic_regs_i (
    .clk(clk), .rstn(rstn), .scl_clk(scl_clk),
    .sda_i(sda_i), .sda_o(), .sda_oe(sda_oe),
    .manual_reset_button_n(pins.btn_n), .channel_enable_pins(pins.en),
    .overheat_warn(pins.hot), .low_input_warn(pins.lvin),
    .ch_power_good(pins.pg), .interrupt_n_o(), .interrupt_n_oe(irq_oe),
    .ch_regulator_on(reg_on), .discharge_en(disch), .hiccup_en(hic),
    .short_latch_en(sc_l), .ov_latch_en(ov_l),
    .btn_switch_mode(sw_mode), .power_good_output(pgood)
  );
  pmic_host pmic_host_i (.scl_clk(scl_clk), .sda_i(sda_i), .sda_oe(sda_oe));

  // ==========================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, d);
    pmic_host_i.wr(a, d);
    cyc(8);
  endtask
  task automatic r(input logic [7:0] a);
    pmic_host_i.rd(a, q);
    cyc(2);
  endtask
  task automatic ev(input int i, input logic a);
    if (i == 5)
      pins.hot = a;
    else if (i == 4)
      pins.lvin = a;
    else
      pins.pg[i] = !a;
  endtask
  task automatic press;
    pins.btn_n = 1'b0;
    cyc(8);
    b = irq_oe;
    pins.btn_n = 1'b1;
    cyc(8);
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2_000_000;
    mismatches++;
    stop_test;
  end

  // ==========================================
  // Tests
  initial begin
    rstn = 1'b0;
    pins = '{btn_n: 1'b1, en: 4'hF, hot: 1'b0, lvin: 1'b0, pg: 4'h1};
    rows = '{
      '{pmic_pkg::ADDR_MASK, 8'hFF, pmic_pkg::ADDR_MASK, 8'hFF},
      '{pmic_pkg::ADDR_PROT, 8'h06, pmic_pkg::ADDR_PROT, 8'h06},
      '{pmic_pkg::ADDR_DISCH, 8'h05, pmic_pkg::ADDR_DISCH, 8'h05},
      '{pmic_pkg::ADDR_DEFAULT, 8'h7E, pmic_pkg::ADDR_PROT, 8'h06},
      '{pmic_pkg::ADDR_DEFAULT, 8'h7F, pmic_pkg::ADDR_PROT, 8'h01},
      '{8'h20, 8'h55, pmic_pkg::ADDR_MASK, 8'h00},
      '{pmic_pkg::ADDR_SHUT, 8'hA9, pmic_pkg::ADDR_DISCH, 8'h0F},
      '{8'h20, 8'h00, 8'h20, 8'h00},
      '{pmic_pkg::ADDR_PWR_CTL, 8'h0F, pmic_pkg::ADDR_PWR_CTL, 8'h0F},
      '{pmic_pkg::ADDR_STATUS, 8'hFF, pmic_pkg::ADDR_STATUS, 8'h0F},
      '{pmic_pkg::ADDR_PGMON, 8'h03, pmic_pkg::ADDR_PGMON, 8'h03}};
    cyc(3);
    rstn = 1'b1;
    cyc(6);
    chk_reg("discharge", 8'h0F, {4'h0, disch});
    chk_bit("hiccup", 1'b1, hic);
    chk_bit("sc_latch", 1'b0, sc_l);
    chk_bit("ov_latch", 1'b0, ov_l);
    chk_bit("btn_mode", 1'b0, sw_mode);
    chk_bit("pgood", 1'b1, pgood);
    pins.pg = 4'hE;
    cyc(8);
    chk_bit("pgood", 1'b0, pgood);
    pins.pg = 4'hF;
    tend("reset");
    foreach (rows[i]) begin
      w(rows[i].wa, rows[i].wd);
      r(rows[i].ra);
      chk_reg("row", rows[i].ex, q);
    end
    tend("rows");
    w(pmic_pkg::ADDR_FLAGS, 8'h7F);
    for (int i = 0; i < 6; i++) begin
      w(pmic_pkg::ADDR_MASK, 8'h00);
      ev(i, 1'b1);
      cyc(10);
      chk_bit("irq_masked", 1'b0, irq_oe);
      w(pmic_pkg::ADDR_MASK, 8'h01 << i);
      chk_bit("irq_on", 1'b1, irq_oe);
      ev(i, 1'b0);
      r(pmic_pkg::ADDR_FLAGS);
      chk_reg("flags", 8'h01 << i, q);
      chk_bit("irq_held", 1'b1, irq_oe);
      w(pmic_pkg::ADDR_FLAGS, 8'h01 << i);
      chk_bit("irq_clr", 1'b0, irq_oe);
    end
    tend("events");
    w(pmic_pkg::ADDR_MASK, 8'h40);
    press;
    chk_bit("irq_btn", 1'b0, b);
    w(pmic_pkg::ADDR_SHUT, pmic_pkg::KEY_SHUT);
    chk_reg("reg_on", 8'h0F, {4'h0, reg_on});
    w(pmic_pkg::ADDR_PROT, 8'h09);
    chk_bit("btn_mode", 1'b1, sw_mode);
    press;
    chk_bit("irq_btn", 1'b1, b);
    w(pmic_pkg::ADDR_FLAGS, 8'h40);
    chk_bit("irq_clr", 1'b0, irq_oe);
    w(pmic_pkg::ADDR_SHUT, 8'hA8);
    chk_reg("reg_on", 8'h0F, {4'h0, reg_on});
    w(pmic_pkg::ADDR_SHUT, pmic_pkg::KEY_SHUT);
    chk_reg("reg_on", 8'h00, {4'h0, reg_on});
    r(pmic_pkg::ADDR_PWR_CTL);
    chk_reg("power_ctl", 8'h00, q);
    tend("commands");
    w(pmic_pkg::ADDR_MASK, 8'h20);
    pins.hot = 1'b1;
    cyc(8);
    chk_bit("irq_hot", 1'b1, irq_oe);
    pins.hot = 1'b0;
    pins.en = 4'h0;
    cyc(12);
    chk_bit("irq_en_low", 1'b0, irq_oe);
    pins.en = 4'hF;
    tend("enables");
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    cyc(6);
    r(pmic_pkg::ADDR_MASK);
    chk_reg("mask", 8'h00, q);
    chk_bit("btn_mode", 1'b0, sw_mode);
    tend("reset2");
    stop_test;
  end
endmodule // pmic_irq_mask_and_commands_bench
